// ### shared/rcr_pkg.sv
`default_nettype none
package rcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_HOST_REQ = 8'h18;
    localparam logic [7:0] OFS_ECA_REQ = 8'h1c;
    localparam logic [7:0] OFS_OSCILLATOR_IDENTIFICATION = 8'h20;
    localparam logic [7:0] OFS_ECB_REQ = 8'h34;

    // Implemented flag masks
    localparam logic [31:0] HOST_REQ_MASK = 32'h0000_0157;
    localparam logic [31:0] ECA_REQ_MASK = 32'h003f_03e7;
    localparam logic [31:0] ECB_REQ_MASK = 32'h0000_3393;

    // Host-side flag positions
    localparam int HOST_RUNTIME_BIT = 8;
    localparam int HOST_UART2_BIT = 6;
    localparam int HOST_FLASH_SPI_BIT = 4;
    localparam int HOST_UART1_BIT = 2;
    localparam int HOST_LPC_BIT = 1;
    localparam int HOST_EMBEDDED_MEMORY_IFACE_BIT = 0;

    // Controller-side flag positions, first register
    localparam int ECA_SMBUS_CONTROLLER_2_BIT = 21;
    localparam int ECA_SMBUS_CONTROLLER_1_BIT = 20;
    localparam int ECA_LINK_MASTER_CTRL_BIT = 9;
    localparam int ECA_SERIAL_DEBUG_PORT_BIT = 5;

    // Controller-side flag positions, second register
    localparam int ECB_OTP_BIT = 13;
    localparam int ECB_PROCESSOR_HOT_MONITOR_BIT = 12;
    localparam int ECB_DMA_BIT = 7;

    localparam logic [31:0] REQ_RESET = 32'h0000_0000;

    // Oscillator identification layout
    localparam int ID_SHRINK_LSB = 0;
    localparam int ID_FOUNDRY_LSB = 2;
    localparam int ID_REVISION_LSB = 4;
    localparam logic [1:0] ID_SHRINK_VAL = 2'h1;   // Arbitrary value
    localparam logic [1:0] ID_FOUNDRY_VAL = 2'h2;  // Arbitrary value
    localparam logic [3:0] ID_REVISION_VAL = 4'h3; // Arbitrary value
    localparam logic [31:0] OSCILLATOR_IDENTIFICATION_WORD = {24'h00_0000, ID_REVISION_VAL, ID_FOUNDRY_VAL, ID_SHRINK_VAL};

    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

// ### shared/rcr_req_if.sv
`default_nettype none
interface rcr_req_if;
    logic [31:0] host_sts;
    logic [31:0] eca_sts;
    logic [31:0] ecb_sts;
    modport collector (output host_sts, output eca_sts, output ecb_sts);
    modport regs (input host_sts, input eca_sts, input ecb_sts);
endinterface
`default_nettype wire

// ### hw/rcr_req_collect.sv
`default_nettype none
module rcr_req_collect (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [31:0] host_en,
    input wire logic [31:0] host_clk_req,
    input wire logic [31:0] eca_en,
    input wire logic [31:0] eca_clk_req,
    input wire logic [31:0] ecb_en,
    input wire logic [31:0] ecb_clk_req,
    rcr_req_if.collector req
);
    logic [31:0] host_r;
    logic [31:0] eca_r;
    logic [31:0] ecb_r;
    wire logic [31:0] host_nxt;
    wire logic [31:0] eca_nxt;
    wire logic [31:0] ecb_nxt;

    // Flag is high only while enabled and still asking for the clock
    assign host_nxt = host_en & host_clk_req & rcr_pkg::HOST_REQ_MASK;
    assign eca_nxt = eca_en & eca_clk_req & rcr_pkg::ECA_REQ_MASK;
    assign ecb_nxt = ecb_en & ecb_clk_req & rcr_pkg::ECB_REQ_MASK;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            host_r <= rcr_pkg::REQ_RESET;
            eca_r <= rcr_pkg::REQ_RESET;
            ecb_r <= rcr_pkg::REQ_RESET;
        end else begin
            host_r <= host_nxt;
            eca_r <= eca_nxt;
            ecb_r <= ecb_nxt;
        end
    end

    assign req.host_sts = host_r;
    assign req.eca_sts = eca_r;
    assign req.ecb_sts = ecb_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_host_req_track: assert property (##1
        host_r == ($past(host_en) & $past(host_clk_req) & rcr_pkg::HOST_REQ_MASK))
        else $error("host request flag does not track enable and request");
    a_disabled_reads_zero: assert property ((eca_en == 32'h0000_0000) |=> (eca_r == 32'h0000_0000))
        else $error("disabled blocks still report a clock request");
    a_ecb_after_reset: assert property ($past(reset) |-> ecb_r == rcr_pkg::REQ_RESET)
        else $error("second controller register not zero after reset");
endmodule
`default_nettype wire

// ### hw/rcr_clock_request_status.sv
`default_nettype none
// Overview of operation
// - Flag high while block enabled and needs clock
// - Flag low when disabled or sleeping, except the serial debug flag while software holds it by a write
// - Host-side request register at 18h
// - First controller request register at 1Ch
// - Second controller register at 34h, resets zero
// - Identification shrink factor in bits 1:0
// - Identification foundry code in bits 3:2
// - Identification revision in bits 7:4
module rcr_clock_request_status (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic [31:0] host_en,
    input wire logic [31:0] host_clk_req,
    input wire logic [31:0] eca_en,
    input wire logic [31:0] eca_clk_req,
    input wire logic [31:0] ecb_en,
    input wire logic [31:0] ecb_clk_req,
    output logic serial_debug_port_clk_keep
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    rcr_req_if req_bus ();

    rcr_req_collect u_collect (
        .clk_sys(clk_sys),
        .reset(reset),
        .host_en(host_en),
        .host_clk_req(host_clk_req),
        .eca_en(eca_en),
        .eca_clk_req(eca_clk_req),
        .ecb_en(ecb_en),
        .ecb_clk_req(ecb_clk_req),
        .req(req_bus.collector)
    );

    logic dbg_keep_r;
    logic [31:0] rdata_r;
    logic rvalid_r;

    wire logic sel_host = hit(bus_addr, rcr_pkg::OFS_HOST_REQ);
    wire logic sel_eca = hit(bus_addr, rcr_pkg::OFS_ECA_REQ);
    wire logic sel_id = hit(bus_addr, rcr_pkg::OFS_OSCILLATOR_IDENTIFICATION);
    wire logic sel_ecb = hit(bus_addr, rcr_pkg::OFS_ECB_REQ);
    wire logic sel_none = !(sel_host || sel_eca || sel_id || sel_ecb);

    // Only the serial debug bit is writable; all else ignores writes
    wire logic dbg_wr = bus_wr && sel_eca;
    wire logic dbg_keep_nxt = dbg_wr ? bus_wdata[rcr_pkg::ECA_SERIAL_DEBUG_PORT_BIT] : dbg_keep_r;

    // Software hold on the debug port clock ORs into its request flag
    wire logic [31:0] dbg_word = rcr_pkg::ECA_REQ_MASK & (32'(dbg_keep_r) << rcr_pkg::ECA_SERIAL_DEBUG_PORT_BIT);
    wire logic [31:0] eca_word = req_bus.eca_sts | dbg_word;

    wire logic [31:0] rdata_nxt =
        sel_host ? req_bus.host_sts :
        sel_eca ? eca_word :
        sel_id ? rcr_pkg::OSCILLATOR_IDENTIFICATION_WORD :
        sel_ecb ? req_bus.ecb_sts :
        rcr_pkg::UNMAPPED_DATA;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dbg_keep_r <= 1'b0;
            rdata_r <= rcr_pkg::UNMAPPED_DATA;
            rvalid_r <= 1'b0;
        end else begin
            dbg_keep_r <= dbg_keep_nxt;
            rvalid_r <= bus_rd;
            if (bus_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign bus_rdata = rdata_r;
    assign bus_rvalid = rvalid_r;
    assign serial_debug_port_clk_keep = dbg_keep_r;

    // Enable and need per block, checked against what a read returns
    wire logic [31:0] host_need = host_en & host_clk_req;
    wire logic [31:0] eca_need = eca_en & eca_clk_req;
    wire logic [31:0] ecb_need = ecb_en & ecb_clk_req;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_read_id;
        bus_rd && sel_id;
    endsequence

    // Reads whose status was captured with reset already low
    sequence s_read_host_settled;
        bus_rd && sel_host && !$past(reset);
    endsequence

    sequence s_read_eca_settled;
        bus_rd && sel_eca && !$past(reset);
    endsequence

    sequence s_read_ecb_settled;
        bus_rd && sel_ecb && !$past(reset);
    endsequence

    sequence s_read_unmapped;
        bus_rd && sel_none;
    endsequence

    // Hard-wired identification word
    a_id_shrink_field: assert property (s_read_id |=>
        bus_rvalid && bus_rdata[rcr_pkg::ID_SHRINK_LSB +: $bits(rcr_pkg::ID_SHRINK_VAL)] == rcr_pkg::ID_SHRINK_VAL)
        else $error("shrink field wrong");
    a_id_foundry_field: assert property (s_read_id |=>
        bus_rdata[rcr_pkg::ID_FOUNDRY_LSB +: $bits(rcr_pkg::ID_FOUNDRY_VAL)] == rcr_pkg::ID_FOUNDRY_VAL)
        else $error("foundry field wrong");
    a_id_revision_field: assert property (s_read_id |=>
        bus_rdata[rcr_pkg::ID_REVISION_LSB +: $bits(rcr_pkg::ID_REVISION_VAL)] == rcr_pkg::ID_REVISION_VAL)
        else $error("revision field wrong");
    a_id_upper_zero: assert property (s_read_id |=>
        (bus_rdata >> (rcr_pkg::ID_REVISION_LSB + $bits(rcr_pkg::ID_REVISION_VAL))) == 32'h0000_0000)
        else $error("identification reserved bits not zero");
    a_host_read_reserved: assert property (bus_rd && sel_host |=> (bus_rdata & ~rcr_pkg::HOST_REQ_MASK) == 32'h0000_0000)
        else $error("host register reserved bits not zero");
    a_eca_read_reserved: assert property (bus_rd && sel_eca |=> (bus_rdata & ~rcr_pkg::ECA_REQ_MASK) == 32'h0000_0000)
        else $error("first controller register reserved bits not zero");
    a_ecb_read_reserved: assert property (bus_rd && sel_ecb |=> (bus_rdata & ~rcr_pkg::ECB_REQ_MASK) == 32'h0000_0000)
        else $error("second controller register reserved bits not zero");
    a_dbg_bit_write: assert property (bus_wr && sel_eca |=>
        serial_debug_port_clk_keep == $past(bus_wdata[rcr_pkg::ECA_SERIAL_DEBUG_PORT_BIT]))
        else $error("serial debug bit did not take written value");
    a_other_write_ignored: assert property (bus_wr && !sel_eca |=> $stable(serial_debug_port_clk_keep))
        else $error("write to read-only location changed state");
    a_dbg_bit_reads_one: assert property (serial_debug_port_clk_keep && bus_rd && sel_eca |=>
        bus_rdata[rcr_pkg::ECA_SERIAL_DEBUG_PORT_BIT])
        else $error("held debug clock request not reported");

    // Answer timing of the read strobe, debug clock hold stability and state after reset
    a_rvalid_after_read: assert property (bus_rd |=> bus_rvalid)
        else $error("read not answered one cycle later");
    a_rvalid_one_pulse: assert property (!bus_rd |=> !bus_rvalid)
        else $error("read answer without a read");
    a_write_no_answer: assert property (bus_wr && !bus_rd |=> !bus_rvalid)
        else $error("write produced a read answer");
    a_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data changed without a read");
    a_keep_needs_write: assert property (!bus_wr |=> $stable(serial_debug_port_clk_keep))
        else $error("debug clock hold changed without a write");
    a_state_after_reset: assert property ($past(reset) |->
        !serial_debug_port_clk_keep && !bus_rvalid && bus_rdata == rcr_pkg::UNMAPPED_DATA)
        else $error("bus side not idle after reset");

    a_host_read_value: assert property (s_read_host_settled |=>
        bus_rdata == ($past(host_need, 2) & rcr_pkg::HOST_REQ_MASK))
        else $error("host register does not show enabled requests");
    a_eca_read_value: assert property (s_read_eca_settled |=>
        bus_rdata == (($past(eca_need, 2) & rcr_pkg::ECA_REQ_MASK) |
        (32'($past(serial_debug_port_clk_keep)) << rcr_pkg::ECA_SERIAL_DEBUG_PORT_BIT)))
        else $error("first controller register does not show enabled requests");
    a_ecb_read_value: assert property (s_read_ecb_settled |=>
        bus_rdata == ($past(ecb_need, 2) & rcr_pkg::ECB_REQ_MASK))
        else $error("second controller register does not show enabled requests");
    a_unmapped_reads_zero: assert property (s_read_unmapped |=> bus_rdata == rcr_pkg::UNMAPPED_DATA)
        else $error("unmapped read not zero");

    // Each named host-side flag follows its own block
    a_runtime_flag: assert property (s_read_host_settled |=>
        bus_rdata[rcr_pkg::HOST_RUNTIME_BIT] == $past(host_need[rcr_pkg::HOST_RUNTIME_BIT], 2))
        else $error("runtime flag wrong");
    a_uart2_flag: assert property (s_read_host_settled |=>
        bus_rdata[rcr_pkg::HOST_UART2_BIT] == $past(host_need[rcr_pkg::HOST_UART2_BIT], 2))
        else $error("second uart flag wrong");
    a_flash_spi_flag: assert property (s_read_host_settled |=>
        bus_rdata[rcr_pkg::HOST_FLASH_SPI_BIT] == $past(host_need[rcr_pkg::HOST_FLASH_SPI_BIT], 2))
        else $error("flash controller flag wrong");
    a_uart1_flag: assert property (s_read_host_settled |=>
        bus_rdata[rcr_pkg::HOST_UART1_BIT] == $past(host_need[rcr_pkg::HOST_UART1_BIT], 2))
        else $error("first uart flag wrong");
    a_lpc_flag: assert property (s_read_host_settled |=>
        bus_rdata[rcr_pkg::HOST_LPC_BIT] == $past(host_need[rcr_pkg::HOST_LPC_BIT], 2))
        else $error("lpc flag wrong");
    a_memory_iface_flag: assert property (s_read_host_settled |=>
        bus_rdata[rcr_pkg::HOST_EMBEDDED_MEMORY_IFACE_BIT] ==
        $past(host_need[rcr_pkg::HOST_EMBEDDED_MEMORY_IFACE_BIT], 2))
        else $error("memory interface flag wrong");

    // Named flags of the first controller register
    a_smbus2_flag: assert property (s_read_eca_settled |=>
        bus_rdata[rcr_pkg::ECA_SMBUS_CONTROLLER_2_BIT] == $past(eca_need[rcr_pkg::ECA_SMBUS_CONTROLLER_2_BIT], 2))
        else $error("second smbus flag wrong");
    a_smbus1_flag: assert property (s_read_eca_settled |=>
        bus_rdata[rcr_pkg::ECA_SMBUS_CONTROLLER_1_BIT] == $past(eca_need[rcr_pkg::ECA_SMBUS_CONTROLLER_1_BIT], 2))
        else $error("first smbus flag wrong");
    a_link_master_flag: assert property (s_read_eca_settled |=>
        bus_rdata[rcr_pkg::ECA_LINK_MASTER_CTRL_BIT] == $past(eca_need[rcr_pkg::ECA_LINK_MASTER_CTRL_BIT], 2))
        else $error("link master flag wrong");
    a_debug_port_flag: assert property (s_read_eca_settled |=>
        bus_rdata[rcr_pkg::ECA_SERIAL_DEBUG_PORT_BIT] ==
        ($past(eca_need[rcr_pkg::ECA_SERIAL_DEBUG_PORT_BIT], 2) || $past(serial_debug_port_clk_keep)))
        else $error("serial debug flag wrong");

    // Named flags of the second controller register
    a_otp_flag: assert property (s_read_ecb_settled |=>
        bus_rdata[rcr_pkg::ECB_OTP_BIT] == $past(ecb_need[rcr_pkg::ECB_OTP_BIT], 2))
        else $error("otp flag wrong");
    a_hot_monitor_flag: assert property (s_read_ecb_settled |=>
        bus_rdata[rcr_pkg::ECB_PROCESSOR_HOT_MONITOR_BIT] ==
        $past(ecb_need[rcr_pkg::ECB_PROCESSOR_HOT_MONITOR_BIT], 2))
        else $error("processor hot flag wrong");
    a_dma_flag: assert property (s_read_ecb_settled |=>
        bus_rdata[rcr_pkg::ECB_DMA_BIT] == $past(ecb_need[rcr_pkg::ECB_DMA_BIT], 2))
        else $error("dma flag wrong");
endmodule
`default_nettype wire

// ### tb/rcr_block_model.sv
`default_nettype none
module rcr_block_model (
    input wire logic [95:0] en_cmd,
    input wire logic [95:0] req_cmd,
    output logic [31:0] host_en,
    output logic [31:0] host_clk_req,
    output logic [31:0] eca_en,
    output logic [31:0] eca_clk_req,
    output logic [31:0] ecb_en,
    output logic [31:0] ecb_clk_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Peripheral blocks hold enable and clock need as levels
    assign {ecb_en, eca_en, host_en} = en_cmd;
    assign {ecb_clk_req, eca_clk_req, host_clk_req} = req_cmd;
endmodule
`default_nettype wire

// ### tb/rcr_clock_request_status_bench.sv
`default_nettype none
module rcr_clock_request_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic [31:0] bus_rdata;
    logic bus_rvalid;
    logic keep;
    logic [95:0] en_cmd = 96'h0;
    logic [95:0] req_cmd = 96'h0;
    logic [31:0] h_en, h_rq, a_en, a_rq, b_en, b_rq;
    int error_cnt = 0;
    int n_checks = 0;
    logic [7:0] ofs [3] = '{rcr_pkg::OFS_HOST_REQ, rcr_pkg::OFS_ECA_REQ, rcr_pkg::OFS_ECB_REQ};
    logic [31:0] msk [3] = '{32'h0000_0157, 32'h003f_03e7, 32'h0000_3393};
    logic [31:0] id_exp = {24'h00_0000, rcr_pkg::ID_REVISION_VAL, rcr_pkg::ID_FOUNDRY_VAL, rcr_pkg::ID_SHRINK_VAL};

    always #4 clk_sys = ~clk_sys;

    rcr_clock_request_status i_rcr_clock_request_status (.clk_sys(clk_sys), .reset(reset),
        .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .host_en(h_en), .host_clk_req(h_rq),
        .eca_en(a_en), .eca_clk_req(a_rq), .ecb_en(b_en), .ecb_clk_req(b_rq),
        .serial_debug_port_clk_keep(keep));
    rcr_block_model i_rcr_block_model (.en_cmd(en_cmd), .req_cmd(req_cmd), .host_en(h_en),
        .host_clk_req(h_rq), .eca_en(a_en), .eca_clk_req(a_rq), .ecb_en(b_en), .ecb_clk_req(b_rq));

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk_sys);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk_sys);
        bus_rd = 1'b0;
        cmp_bit(bus_rvalid, 1'b1);
        cmp_word(bus_rdata, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk_sys);
        bus_wr = 1'b0;
    endtask

    task automatic end_sim;
        $display("checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        cmp_bit(keep, 1'b0);
        rd(rcr_pkg::OFS_ECB_REQ, 32'h0000_0000);
        rd(rcr_pkg::OFS_OSCILLATOR_IDENTIFICATION, id_exp);
        wr(rcr_pkg::OFS_OSCILLATOR_IDENTIFICATION, 32'hffff_ffff);
        cmp_bit(bus_rvalid, 1'b0);
        rd(rcr_pkg::OFS_OSCILLATOR_IDENTIFICATION, id_exp);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 32; i++) begin
                en_cmd = 96'h0;
                en_cmd[32 * r + i] = 1'b1;
                req_cmd = en_cmd;
                rd(ofs[r], msk[r] & (32'h0000_0001 << i));
            end
            en_cmd = {96{1'b1}};
            req_cmd = 96'h0;
            rd(ofs[r], 32'h0000_0000);
            en_cmd = 96'h0;
            req_cmd = {96{1'b1}};
            rd(ofs[r], 32'h0000_0000);
        end
        req_cmd = 96'h0;
        wr(rcr_pkg::OFS_HOST_REQ, 32'hffff_ffff);
        wr(rcr_pkg::OFS_ECA_REQ, 32'hffff_ffff);
        cmp_bit(keep, 1'b1);
        rd(rcr_pkg::OFS_ECA_REQ, 32'h0000_0020);
        rd(rcr_pkg::OFS_HOST_REQ, 32'h0000_0000);
        wr(rcr_pkg::OFS_ECA_REQ, 32'hffff_ffdf);
        cmp_bit(keep, 1'b0);
        rd(8'h24, 32'h0000_0000);
        end_sim;
    end

    initial begin
        #20000;
        error_cnt++;
        end_sim;
    end
endmodule
`default_nettype wire
